/* File: logic/fbt_unit.sv */
// flag-driven automatic branch and illegal-instruction trap unit
//////////////////////////////////////////////////////////////////////////////
// Contract
// - product bit set when mask and flag set
// - bit 51 is live OR of product
// - bits 51 and 52 start flag branch
// - branch waits for instruction termination
// - next instruction address into entry 01
// - fetch redirected to entry 02 address
// - taking branch clears enable bit 52; a flag write setting bit 52 in the same cycle keeps it set
// - upper 16 bits of entry 01 cleared
// - no branch while bit 52 clear
// - interval timer sets bit 36 anytime
// - branch may lag up to 35 instructions
// - flag copy holds all earlier activity
// - store-related branches within two instructions
// - flag writes may pass pipeline instructions
// - flag-write branch within two instructions
// - entries 1,2,4 may race branches
// - job-mode illegal opcode exchanges to entry 3
// - monitor-mode illegal opcode branches to entry 4
// - decimal fault bit 38, overflow bit 39
//////////////////////////////////////////////////////////////////////////////
`include "fbt_defs.svh"

module fbt_unit #(
    parameter int TIMER_W = 32
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire fbt_pkg::fbt_addr_t reg_addr_in,
    input wire fbt_pkg::fbt_word_t reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output fbt_pkg::fbt_word_t reg_rdata_out,
    input wire logic instr_done_in,
    input wire fbt_pkg::fbt_baddr_t instr_next_addr_in,
    input wire logic flag_set_valid_in,
    input wire logic [15:0] flag_set_in,
    input wire logic dec_fault_in,
    input wire logic dec_overflow_in,
    input wire logic flag_store_in,
    input wire logic illegal_op_in,
    input wire logic monitor_mode_in,
    input wire fbt_pkg::fbt_baddr_t rf_entry2_in,
    input wire fbt_pkg::fbt_baddr_t rf_entry3_in,
    input wire fbt_pkg::fbt_baddr_t rf_entry4_in,
    output logic rf_wr_out,
    output logic [2:0] rf_wr_idx_out,
    output fbt_pkg::fbt_word_t rf_wr_data_out,
    output logic redirect_out,
    output fbt_pkg::fbt_baddr_t redirect_addr_out,
    output logic exchange_out,
    output logic hold_out,
    output logic flag_copy_valid_out,
    output fbt_pkg::fbt_word_t flag_copy_out
);
    import fbt_pkg::*;

    //////////////////////////////////////////////////////////////////////////
    // elaboration check
    generate
        if (TIMER_W < 2 || TIMER_W > 64) begin : g_bad_timer
            $error("fbt_unit: TIMER_W must lie in 2..64");
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////////
    // flag word image: product and summary are always derived
    function automatic fbt_word_t fbt_image(input logic [15:0] m, input logic [15:0] d, input logic [15:0] f);
        fbt_word_t w;
        w = {f, d, m, m & d};
        w[`FBT_SUMMARY_BIT] = |(m & d);
        return w;
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // state
    logic [15:0] mask_q;
    logic [15:0] data_q;
    logic [15:0] free_q;
    logic [TIMER_W-1:0] timer_q;
    logic timer_run;
    fbt_state_t state;
    logic trap_job;
    logic [1:0] store_age;
    logic [5:0] cond_age;

    logic [15:0] product;
    logic summary;
    logic enable;
    logic wr_flag;
    logic wr_timer;
    logic timer_fire;
    logic take_branch;
    logic take_trap;
    logic [15:0] hw_set;
    logic [15:0] next_mask;
    logic [15:0] next_data;
    logic [15:0] next_free;
    fbt_word_t cur_image;

    //////////////////////////////////////////////////////////////////////////
    // live product field and summary, no instruction boundary involved
    always_comb begin
        product = mask_q & data_q;
        summary = |product;
        enable = free_q[`FBT_ENABLE_BIT - `FBT_FREE_LSB];
        cur_image = fbt_image(mask_q, data_q, free_q);
    end

    // register port decode
    assign wr_flag = reg_wr_in && (reg_addr_in == `FBT_OFS_FLAG);
    assign wr_timer = reg_wr_in && (reg_addr_in == `FBT_OFS_TIMER);

    // timer expiry is independent of the instruction stream
    assign timer_fire = timer_run && (timer_q == {{(TIMER_W-1){1'b0}}, 1'b1});

    // branch starts only at instruction termination, with enable set
    assign take_trap = (state == FBT_RUN) && illegal_op_in;
    assign take_branch = (state == FBT_RUN) && instr_done_in && summary && enable
        && !illegal_op_in;   // a flag write is seen at the very next termination

    // pipeline must stall while a redirect sequence runs
    assign hold_out = (state != FBT_RUN);

    //////////////////////////////////////////////////////////////////////////
    // hardware flag sources, merged into the data flag field
    always_comb begin
        hw_set = 16'h0000;
        if (flag_set_valid_in) begin
            hw_set = flag_set_in;
        end
        if (timer_fire) begin
            hw_set[`FBT_TIMER_BIT - `FBT_DATA_LSB] = 1'b1;
        end
        if (dec_fault_in) begin
            hw_set[`FBT_FAULT_BIT - `FBT_DATA_LSB] = 1'b1;
        end
        if (dec_overflow_in) begin
            hw_set[`FBT_OVF_BIT - `FBT_DATA_LSB] = 1'b1;
        end
    end

    // next field values: hardware sets win over a software clear
    always_comb begin
        next_mask = mask_q;
        next_data = data_q | hw_set;
        next_free = free_q;
        if (wr_flag) begin
            // flag writes act at once, ahead of pending pipeline work
            next_mask = reg_wdata_in[`FBT_MASK_LSB +: `FBT_FIELD_W];
            next_data = reg_wdata_in[`FBT_DATA_LSB +: `FBT_FIELD_W] | hw_set;
            next_free = reg_wdata_in[`FBT_FREE_LSB +: `FBT_FIELD_W];
        end
        if (take_branch && !(wr_flag && reg_wdata_in[`FBT_ENABLE_BIT])) begin
            next_free[`FBT_ENABLE_BIT - `FBT_FREE_LSB] = 1'b0;
        end
        // summary slot is derived, never stored
        next_free[`FBT_SUMMARY_BIT - `FBT_FREE_LSB] = 1'b0;
    end

    //////////////////////////////////////////////////////////////////////////
    // flag register fields
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            mask_q <= `FBT_MASK_RST;
            data_q <= `FBT_DATA_RST;
            free_q <= `FBT_FREE_RST;
        end else begin
            mask_q <= next_mask;
            data_q <= next_data;
            free_q <= next_free;
        end
    end

    // job interval timer, counts down every clock from a nonzero load until it fires
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            timer_q <= '0;
            timer_run <= 1'b0;
        end else if (wr_timer) begin
            timer_q <= reg_wdata_in[TIMER_W-1:0];
            timer_run <= (reg_wdata_in[TIMER_W-1:0] != '0);
        end else if (timer_run) begin
            timer_q <= timer_q - 1'b1;
            timer_run <= !timer_fire;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // redirect sequencer
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state <= FBT_RUN;
            trap_job <= 1'b0;
        end else begin
            case (state)
                FBT_RUN: begin
                    if (take_trap) begin
                        state <= FBT_TRAP;
                        trap_job <= !monitor_mode_in;
                    end else if (take_branch) begin
                        state <= FBT_SAVE;
                    end
                end
                FBT_SAVE: begin
                    state <= FBT_JUMP;
                end
                FBT_JUMP: begin
                    state <= FBT_RUN;
                end
                FBT_TRAP: begin
                    state <= FBT_RUN;
                end
                default: begin
                    state <= FBT_RUN;
                end
            endcase
        end
    end

    // register-file write of the return word
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rf_wr_out <= 1'b0;
            rf_wr_idx_out <= 3'h0;
            rf_wr_data_out <= '0;
        end else begin
            rf_wr_out <= take_branch;
            if (take_branch) begin
                rf_wr_idx_out <= `FBT_RF_RET;
                rf_wr_data_out <= {16'h0000, instr_next_addr_in};
            end
        end
    end

    // fetch redirect; entries 2..4 are read late so a racing write may or may not land
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            redirect_out <= 1'b0;
            redirect_addr_out <= '0;
            exchange_out <= 1'b0;
        end else begin
            redirect_out <= take_trap || (state == FBT_SAVE);
            exchange_out <= take_trap && !monitor_mode_in;
            if (state == FBT_SAVE) begin
                redirect_addr_out <= rf_entry2_in;
            end else if (take_trap && !monitor_mode_in) begin
                redirect_addr_out <= rf_entry3_in;
            end else if (take_trap) begin
                redirect_addr_out <= rf_entry4_in;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // flag copy carries every update of the same cycle
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            flag_copy_valid_out <= 1'b0;
            flag_copy_out <= '0;
        end else begin
            flag_copy_valid_out <= flag_store_in;
            if (flag_store_in) begin
                flag_copy_out <= fbt_image(next_mask, next_data, next_free);
            end
        end
    end

    // instructions since a flag store while a branch is pending
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            store_age <= 2'h0;
        end else if (flag_store_in) begin
            store_age <= 2'h0;
        end else if (instr_done_in && summary && enable && !take_branch && store_age != 2'h3) begin
            store_age <= store_age + 2'h1;
        end
    end

    // instructions a pending condition has waited, saturating
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cond_age <= 6'h00;
        end else if (!(summary && enable) || take_branch) begin
            cond_age <= 6'h00;
        end else if (instr_done_in && cond_age != 6'h3f) begin
            cond_age <= cond_age + 6'h01;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // read port, data stand one cycle only, unmapped reads zero
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            reg_rdata_out <= '0;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                `FBT_OFS_FLAG: reg_rdata_out <= cur_image;
                `FBT_OFS_TIMER: reg_rdata_out <= 64'(timer_q);
                `FBT_OFS_STATUS: reg_rdata_out <= {46'h0, cond_age, store_age, 4'h0,
                                                   trap_job, timer_run, enable, summary, state};
                default: reg_rdata_out <= '0;
            endcase
        end else begin
            reg_rdata_out <= '0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_save;
        rf_wr_out && (rf_wr_idx_out == `FBT_RF_RET) && !redirect_out;
    endsequence

    sequence s_jump;
        redirect_out && !rf_wr_out && !exchange_out;
    endsequence

    property p_product_set;
        flag_set_valid_in && ((flag_set_in & mask_q) != 16'h0000) && !wr_flag |=> summary;
    endproperty
    a_product_set: assert property (p_product_set) else $error("masked flag did not set summary");

    property p_summary_read;
        reg_rd_in && (reg_addr_in == `FBT_OFS_FLAG) |=>
            reg_rdata_out[`FBT_SUMMARY_BIT] == |($past(mask_q) & $past(data_q));
    endproperty
    a_summary_read: assert property (p_summary_read) else $error("bit 51 read not OR of product");

    property p_branch_seq;
        (state == FBT_RUN) && instr_done_in && summary && enable && !illegal_op_in |=> s_save ##1 s_jump;
    endproperty
    a_branch_seq: assert property (p_branch_seq) else $error("flag branch sequence wrong");

    property p_wait_done;
        (state == FBT_RUN) && !instr_done_in |=> !rf_wr_out;
    endproperty
    a_wait_done: assert property (p_wait_done) else $error("branch before instruction end");

    property p_ret_word;
        take_branch |=> rf_wr_data_out[47:0] == $past(instr_next_addr_in);
    endproperty
    a_ret_word: assert property (p_ret_word) else $error("return address wrong");

    property p_target;
        (state == FBT_SAVE) |=> redirect_addr_out == $past(rf_entry2_in);
    endproperty
    a_target: assert property (p_target) else $error("branch target not entry 02");

    property p_clear_enable;
        take_branch && !wr_flag |=> !enable ##1 !rf_wr_out;
    endproperty
    a_clear_enable: assert property (p_clear_enable) else $error("enable not cleared");

    property p_upper_clear;
        rf_wr_out |-> rf_wr_data_out[63:48] == 16'h0000;
    endproperty
    a_upper_clear: assert property (p_upper_clear) else $error("entry 01 upper bits set");

    property p_disabled;
        !enable |=> !rf_wr_out;
    endproperty
    a_disabled: assert property (p_disabled) else $error("branch with enable clear");

    property p_timer;
        timer_fire |=> data_q[`FBT_TIMER_BIT - `FBT_DATA_LSB] && !timer_run;
    endproperty
    a_timer: assert property (p_timer) else $error("timer did not set bit 36");

    property p_copy;
        flag_store_in |=> flag_copy_valid_out && (flag_copy_out == cur_image);
    endproperty
    a_copy: assert property (p_copy) else $error("flag copy stale");

    property p_store_bound;
        store_age <= 2'(`FBT_STORE_BOUND);
    endproperty
    a_store_bound: assert property (p_store_bound) else $error("branch later than two instructions");

    property p_trap_job;
        take_trap && !monitor_mode_in |=> exchange_out && redirect_out && (redirect_addr_out == $past(rf_entry3_in));
    endproperty
    a_trap_job: assert property (p_trap_job) else $error("job trap wrong");

    property p_trap_mon;
        take_trap && monitor_mode_in |=> !exchange_out && redirect_out && (redirect_addr_out == $past(rf_entry4_in));
    endproperty
    a_trap_mon: assert property (p_trap_mon) else $error("monitor trap wrong");

    property p_dec_flags;
        dec_fault_in && dec_overflow_in |=> data_q[`FBT_FAULT_BIT - `FBT_DATA_LSB] && data_q[`FBT_OVF_BIT - `FBT_DATA_LSB];
    endproperty
    a_dec_flags: assert property (p_dec_flags) else $error("decimal flags not set");

    property p_product_clear;
        wr_flag && (reg_wdata_in[`FBT_MASK_LSB +: `FBT_FIELD_W] == 16'h0000) |=> !summary;
    endproperty
    a_product_clear: assert property (p_product_clear) else $error("product did not clear");

endmodule // fbt_unit

/* File: logic/fbt_defs.svh */
// constants for the flag branch and trap unit
`ifndef FBT_DEFS_SVH
`define FBT_DEFS_SVH
// register offsets on the register port
`define FBT_OFS_FLAG 8'h00
`define FBT_OFS_TIMER 8'h08
`define FBT_OFS_STATUS 8'h10
// flag register field positions (bit n of the word is flag bit n)
`define FBT_FIELD_W 16
`define FBT_PROD_LSB 0
`define FBT_MASK_LSB 16
`define FBT_DATA_LSB 32
`define FBT_FREE_LSB 48
`define FBT_TIMER_BIT 36
`define FBT_FAULT_BIT 38
`define FBT_OVF_BIT 39
`define FBT_SUMMARY_BIT 51
`define FBT_ENABLE_BIT 52
// branch address width and register-file entries
`define FBT_BADDR_W 48
`define FBT_RF_RET 3'h1
`define FBT_RF_TGT 3'h2
`define FBT_RF_JOB 3'h3
`define FBT_RF_MON 3'h4
// reset values
`define FBT_MASK_RST 16'h0000
`define FBT_DATA_RST 16'h0000
`define FBT_FREE_RST 16'h0000
// instruction counts bounding the branch
`define FBT_MAX_DELAY 35
`define FBT_STORE_BOUND 2
`endif

/* File: logic/fbt_pkg.sv */
// types shared by the flag branch and trap unit
package fbt_pkg;
    typedef enum logic [1:0] {FBT_RUN, FBT_SAVE, FBT_JUMP, FBT_TRAP} fbt_state_t;
    typedef logic [7:0] fbt_addr_t;
    typedef logic [63:0] fbt_word_t;
    typedef logic [47:0] fbt_baddr_t;
endpackage

/* File: dv/fbt_rf_model.sv */
// register file and fetch model on the far side of the flag branch unit
module fbt_rf_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic rf_wr_in,
    input wire logic [2:0] rf_wr_idx_in,
    input wire fbt_pkg::fbt_word_t rf_wr_data_in,
    input wire logic redirect_in,
    input wire fbt_pkg::fbt_baddr_t redirect_addr_in,
    input wire logic exchange_in,
    input wire logic ld_in,
    input wire logic [2:0] ld_idx_in,
    input wire fbt_pkg::fbt_word_t ld_data_in,
    output fbt_pkg::fbt_word_t entry1_out,
    output fbt_pkg::fbt_baddr_t entry2_out,
    output fbt_pkg::fbt_baddr_t entry3_out,
    output fbt_pkg::fbt_baddr_t entry4_out,
    output fbt_pkg::fbt_baddr_t fetch_out,
    output logic monitor_mode_out
);
    timeunit 1ns;
    timeprecision 100ps;
    import fbt_pkg::*;
    fbt_word_t rf [8];
    //////////////////////////////////////////////////////////////////////////
    // entry writes: unit write wins over a program load in the same cycle
    always_ff @(posedge clk_in) begin
        if (rf_wr_in) begin
            rf[rf_wr_idx_in] <= rf_wr_data_in;
        end else if (ld_in) begin
            rf[ld_idx_in] <= ld_data_in;
        end
    end
    // fetch follows every redirect, exchange enters monitor mode
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            fetch_out <= '0;
            monitor_mode_out <= 1'b0;
        end else begin
            if (redirect_in) begin
                fetch_out <= redirect_addr_in;
            end
            if (exchange_in) begin
                monitor_mode_out <= 1'b1;
            end
        end
    end
    // register contents seen by the unit (entries 2..4) and the bench (entry 1)
    assign entry1_out = rf[1];
    assign entry2_out = rf[2][47:0];
    assign entry3_out = rf[3][47:0];
    assign entry4_out = rf[4][47:0];
endmodule // fbt_rf_model

/* File: dv/tb.sv */
// self-checking bench for the flag branch and trap unit
`include "fbt_defs.svh"
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import fbt_pkg::*;
    logic clk_in, rst_in, reg_wr, reg_rd, instr_done, fsv, dfault, dovf, fstore, illegal, ld;
    logic rf_wr, redir, exch, hold, cvalid, mon;
    logic [2:0] rf_idx, ld_idx;
    logic [15:0] fset;
    fbt_addr_t reg_addr;
    fbt_word_t wdata, rdata, rf_data, copy, ld_data, e1;
    fbt_baddr_t next_addr, e2, e3, e4, raddr, fetch;
    int fails = 0;
    int compares = 0;
    //////////////////////////////////////////////////////////////////////////
    // units under test
    fbt_unit #(.TIMER_W(32)) fbt_unit_i (.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr),
        .reg_wdata_in(wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata),
        .instr_done_in(instr_done), .instr_next_addr_in(next_addr), .flag_set_valid_in(fsv),
        .flag_set_in(fset), .dec_fault_in(dfault), .dec_overflow_in(dovf), .flag_store_in(fstore),
        .illegal_op_in(illegal), .monitor_mode_in(mon), .rf_entry2_in(e2), .rf_entry3_in(e3),
        .rf_entry4_in(e4), .rf_wr_out(rf_wr), .rf_wr_idx_out(rf_idx), .rf_wr_data_out(rf_data),
        .redirect_out(redir), .redirect_addr_out(raddr), .exchange_out(exch), .hold_out(hold),
        .flag_copy_valid_out(cvalid), .flag_copy_out(copy));
    fbt_rf_model fbt_rf_model_i (.clk_in(clk_in), .rst_in(rst_in), .rf_wr_in(rf_wr),
        .rf_wr_idx_in(rf_idx), .rf_wr_data_in(rf_data), .redirect_in(redir), .redirect_addr_in(raddr),
        .exchange_in(exch), .ld_in(ld), .ld_idx_in(ld_idx), .ld_data_in(ld_data), .entry1_out(e1),
        .entry2_out(e2), .entry3_out(e3), .entry4_out(e4), .fetch_out(fetch), .monitor_mode_out(mon));
    //////////////////////////////////////////////////////////////////////////
    // clock at 25 ns
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    // expected flag word from mask, data flags and enable
    function automatic fbt_word_t img(input logic [15:0] m, input logic [15:0] d, input logic en);
        return {11'h0, en, |(m & d), 3'h0, d, m, m & d};
    endfunction
    task automatic chk(input string what, input fbt_word_t exp, input fbt_word_t got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bus_wr(input fbt_addr_t a, input fbt_word_t d);
        @(posedge clk_in);
        reg_addr <= a;
        wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_in);
        reg_wr <= 1'b0;
    endtask
    task automatic chk_rd(input fbt_addr_t a, input fbt_word_t exp);
        @(posedge clk_in);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_in);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata", exp, rdata);
    endtask
    task automatic ld_word(input logic [2:0] i, input fbt_word_t d);
        @(posedge clk_in);
        ld <= 1'b1;
        ld_idx <= i;
        ld_data <= d;
        @(posedge clk_in);
        ld <= 1'b0;
    endtask
    task automatic done_pulse(input fbt_baddr_t a);
        @(posedge clk_in);
        instr_done <= 1'b1;
        next_addr <= a;
        @(posedge clk_in);
        instr_done <= 1'b0;
        #1;
    endtask
    //////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset();
        chk("hold", 0, hold);
        chk_rd(`FBT_OFS_FLAG, 64'h0);
        chk_rd(8'h18, 64'h0);
    endtask
    task automatic t_product();
        bus_wr(`FBT_OFS_FLAG, img(16'h0005, 16'h0000, 1'b0));
        @(posedge clk_in);
        fsv <= 1'b1;
        fset <= 16'h0003;
        @(posedge clk_in);
        fsv <= 1'b0;
        chk_rd(`FBT_OFS_FLAG, img(16'h0005, 16'h0003, 1'b0));
        bus_wr(`FBT_OFS_FLAG, 64'h0008_0003_0000_ffff);
        chk_rd(`FBT_OFS_FLAG, img(16'h0000, 16'h0003, 1'b0));
    endtask
    task automatic t_nobranch();
        bus_wr(`FBT_OFS_FLAG, img(16'h0005, 16'h0003, 1'b0));
        done_pulse(48'h0000_0000_0100);
        chk("rf_wr", 0, rf_wr);
        @(posedge clk_in);
        #1 chk("redirect", 0, redir);
    endtask
    task automatic t_branch();
        fbt_baddr_t a;
        a = 48'h0000_1234_5670;
        ld_word(3'h1, 64'hffff_0000_0000_0001);
        ld_word(3'h2, 64'h0000_abc0_0000_1000);
        bus_wr(`FBT_OFS_FLAG, img(16'h0005, 16'h0003, 1'b1));
        repeat (3) @(posedge clk_in);
        #1 chk("early rf_wr", 0, rf_wr);
        done_pulse(a);
        chk("rf_wr", 1, rf_wr);
        chk("rf_idx", 1, rf_idx);
        chk("rf_data", {16'h0, a}, rf_data);
        chk("hold", 1, hold);
        @(posedge clk_in);
        #1 chk("redirect", 1, redir);
        chk("redirect_addr", 48'habc0_0000_1000, raddr);
        @(posedge clk_in);
        #1 chk("entry1", {16'h0, a}, e1);
        chk("fetch", 48'habc0_0000_1000, fetch);
        chk_rd(`FBT_OFS_FLAG, img(16'h0005, 16'h0003, 1'b0));
        // program clears the cause and sees the summary low before enabling
        bus_wr(`FBT_OFS_FLAG, img(16'h0000, 16'h0003, 1'b0));
        chk_rd(`FBT_OFS_FLAG, img(16'h0000, 16'h0003, 1'b0));
        bus_wr(`FBT_OFS_FLAG, img(16'h0000, 16'h0003, 1'b1));
        done_pulse(a);
        chk("rf_wr", 0, rf_wr);
    endtask
    task automatic t_trap();
        ld_word(3'h3, 64'h0000_0000_0000_3000);
        ld_word(3'h4, 64'h0000_0000_0000_4000);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk_in);
            illegal <= 1'b1;
            @(posedge clk_in);
            illegal <= 1'b0;
            #1 chk("redirect", 1, redir);
            chk("redirect_addr", (i == 0) ? 64'h3000 : 64'h4000, raddr);
            chk("exchange", (i == 0) ? 64'h1 : 64'h0, exch);
            @(posedge clk_in);
            #1 chk("monitor", 1, mon);
        end
        // status: idle, enable set, summary low, last trap from monitor mode
        chk_rd(`FBT_OFS_STATUS, 64'h8);
    endtask
    task automatic t_store();
        bus_wr(`FBT_OFS_FLAG, 64'h0);
        @(posedge clk_in);
        dfault <= 1'b1;
        fstore <= 1'b1;
        @(posedge clk_in);
        dfault <= 1'b0;
        fstore <= 1'b0;
        #1 chk("copy_valid", 1, cvalid);
        chk("copy", 64'h0000_0040_0000_0000, copy);
        @(posedge clk_in);
        dovf <= 1'b1;
        @(posedge clk_in);
        dovf <= 1'b0;
        bus_wr(`FBT_OFS_TIMER, 64'h5);
        // one count gone by the read edge
        chk_rd(`FBT_OFS_TIMER, 64'h4);
        chk_rd(`FBT_OFS_FLAG, 64'h0000_00c0_0000_0000);
        repeat (8) @(posedge clk_in);
        chk_rd(`FBT_OFS_FLAG, 64'h0000_00d0_0000_0000);
    endtask
    //////////////////////////////////////////////////////////////////////////
    // verdict and end of run
    task automatic summarize();
        if (fails == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // watchdog well beyond the expected hundred or so cycles
    initial begin
        #500000;
        fails++;
        summarize();
    end
    // reset then scenarios
    initial begin
        rst_in = 1'b1;
        {reg_wr, reg_rd, instr_done, fsv, dfault, dovf, fstore, illegal, ld} = '0;
        reg_addr = '0;
        wdata = '0;
        fset = '0;
        next_addr = '0;
        ld_idx = '0;
        ld_data = '0;
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        t_reset();
        t_product();
        t_nobranch();
        t_branch();
        t_trap();
        t_store();
        summarize();
    end
endmodule // tb
